//--- core/lcsd_top.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Line clock select and divider
// ****************************************
module lcsd_top
   import lcsd_pkg::*;
(
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB request
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   // APB answer
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // PLL clocks, sampled as levels
   input wire logic pll0_clk,
   input wire logic pll1_clk,
   input wire logic pll2_clk,
   input wire logic pll3_clk,
   // Line receive and external clocks
   input wire logic [15:0] e1_rx_clk,
   input wire logic [3:0] e3_rx_clk,
   input wire logic ext_clk,
   // Differential channels
   output logic [7:0] diff_out_clock_source_out,
   output logic [7:0] diff_drv_oe,
   output logic [7:0] rx_rise_edge,
   // Interface group clocks
   output logic e3_group_clk,
   output logic e1_hi_group_clk,
   output logic e1_lo_group_clk
);

   // ****************************************
   // Declarations
   // ****************************************
   lcsd_state_s s_r;
   lcsd_state_s s_nxt;
   logic [1:0] ps_src;
   logic [15:0] ps_div [2];
   logic [1:0] ps_out;
   logic [31:0] dsrc;
   logic [31:0] e3src;
   logic [31:0] hisrc;
   logic [31:0] losrc;
   logic access;
   logic wr_en;

   // ****************************************
   // Functions
   // ****************************************

   // Address decode, used by write and error paths
   function automatic logic addr_hit(input logic [7:0] a);
      case (a)
         ADDR_SEL, ADDR_DRV, ADDR_EDGE, ADDR_DIV0, ADDR_DIV1: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   endfunction

   // Read data for one register; unused bits read zero
   function automatic logic [31:0] rd_word(input lcsd_state_s s, input logic [7:0] a);
      case (a)
         ADDR_SEL: rd_word = {24'h000000, s.sel};
         ADDR_DRV: rd_word = {28'h0000000, s.drv};
         ADDR_EDGE: rd_word = {24'h000000, s.edge_sel};
         ADDR_DIV0: rd_word = {16'h0000, s.div0};
         ADDR_DIV1: rd_word = {16'h0000, s.div1};
         default: rd_word = 32'h00000000;
      endcase
   endfunction

   // Glitch-free source switch: leave the old source only while it is
   // low, park low, and join the new source only while it is low
   function automatic lcsd_mux_s mux_step(input lcsd_mux_s m, input logic [31:0] src,
                                         input logic [4:0] req);
      lcsd_mux_s n;
      n = m;
      case (m.mode)
         LCSD_FOLLOW: begin
            n.out = src[m.cur];
            if (req != m.cur && !src[m.cur]) begin
               n.mode = LCSD_PARK;
               n.out = 1'b0;
            end
         end
         LCSD_PARK: begin
            n.out = 1'b0;
            if (!src[req]) begin
               n.cur = req;
               n.mode = LCSD_FOLLOW;
            end
         end
         default: begin
            n.mode = LCSD_FOLLOW;
            n.out = 1'b0;
         end
      endcase
      return n;
   endfunction

   // ****************************************
   // Post-scalers for PLL 0 and PLL 1
   // ****************************************
   assign ps_src[0] = pll0_clk;
   assign ps_src[1] = pll1_clk;
   assign ps_div[0] = s_r.div0;
   assign ps_div[1] = s_r.div1;

   // One scaler per divided PLL
   generate
      for (genvar g = 0; g < 2; g++) begin : g_ps
         lcsd_ps_if ps_bus ();
         assign ps_bus.src = ps_src[g];
         assign ps_bus.div = ps_div[g];
         assign ps_out[g] = ps_bus.out;
         lcsd_post_scaler u_ps (
            .pclk(pclk),
            .presetn(presetn),
            .bus(ps_bus.scaler)
         );
      end
   endgenerate

   // ****************************************
   // Source tables
   // ****************************************

   // Differential source by code; undefined codes stay low
   assign dsrc = {10'h000, ext_clk, e3_rx_clk, e1_rx_clk, ps_out[1]};

   // Group sources: code 0 the PLL clock, code 1 the external clock
   assign e3src = {30'h00000000, ext_clk, pll2_clk};
   assign hisrc = {30'h00000000, ext_clk, ps_out[0]};
   assign losrc = {30'h00000000, ext_clk, pll3_clk};

   // ****************************************
   // Register file and clock muxes
   // ****************************************
   assign access = psel && penable;
   assign wr_en = access && pwrite && addr_hit(paddr);

   // Next state
   always_comb begin
      s_nxt = s_r;
      // Setup cycle fetches read data for the access phase
      if (psel && !penable) begin
         s_nxt.rdata = rd_word(s_r, paddr);
      end
      // Writes land at the end of the access phase
      if (wr_en) begin
         case (paddr)
            ADDR_SEL: s_nxt.sel = pwdata[7:0];
            ADDR_DRV: s_nxt.drv = pwdata[3:0];
            ADDR_EDGE: s_nxt.edge_sel = pwdata[7:0];
            ADDR_DIV0: s_nxt.div0 = pwdata[15:0];
            ADDR_DIV1: s_nxt.div1 = pwdata[15:0];
            default: s_nxt.rdata = s_r.rdata;
         endcase
      end
      // Clock selection
      s_nxt.dm = mux_step(s_r.dm, dsrc, s_r.sel[SEL_DIFF_MSB:SEL_DIFF_LSB]);
      s_nxt.e3m = mux_step(s_r.e3m, e3src, {4'h0, s_r.sel[SEL_E3_BIT]});
      s_nxt.hm = mux_step(s_r.hm, hisrc, {4'h0, s_r.sel[SEL_E1HI_BIT]});
      s_nxt.lm = mux_step(s_r.lm, losrc, {4'h0, s_r.sel[SEL_E1LO_BIT]});
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.sel <= RST_SEL;
         s_r.drv <= RST_DRV;
         s_r.edge_sel <= RST_EDGE;
         s_r.div0 <= RST_DIV;
         s_r.div1 <= RST_DIV;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************

   // APB answer: no wait states, error on unmapped address
   assign pready = 1'b1;
   assign pslverr = access && !addr_hit(paddr);
   assign prdata = s_r.rdata;

   // One shared transmit clock for all differential channels
   assign diff_out_clock_source_out = {8{s_r.dm.out}};
   assign rx_rise_edge = s_r.edge_sel;
   assign e3_group_clk = s_r.e3m.out;
   assign e1_hi_group_clk = s_r.hm.out;
   assign e1_lo_group_clk = s_r.lm.out;

   // Each enable bit drives one channel pair
   generate
      for (genvar p = 0; p < 4; p++) begin : g_drv
         assign diff_drv_oe[2*p+1:2*p] = {2{s_r.drv[p]}};
      end
   endgenerate

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Delayed inputs for the checks
   logic [15:0] e1_q;
   logic [3:0] e3_q;
   logic ext_q;
   always_ff @(posedge pclk) begin
      e1_q <= e1_rx_clk;
      e3_q <= e3_rx_clk;
      ext_q <= ext_clk;
   end

   chk_diff_pll: assert property (
      (s_r.dm.mode == LCSD_FOLLOW && s_r.dm.cur == CODE_PLL1)
      |-> diff_out_clock_source_out == {8{$past(ps_out[1])}})
      else $error("differential clock not following divided PLL 1");

   chk_diff_e1: assert property (
      (s_r.dm.mode == LCSD_FOLLOW && s_r.dm.cur >= CODE_E1_FIRST
       && s_r.dm.cur < CODE_E3_FIRST)
      |-> diff_out_clock_source_out[5] == e1_q[4'(s_r.dm.cur - CODE_E1_FIRST)])
      else $error("differential clock not following chosen low-rate clock");

   chk_diff_e3_ext: assert property (
      (s_r.dm.mode == LCSD_FOLLOW && s_r.dm.cur >= CODE_E3_FIRST)
      |-> diff_out_clock_source_out[2] == ((s_r.dm.cur < CODE_EXT)
          ? e3_q[2'(s_r.dm.cur - CODE_E3_FIRST)]
          : ((s_r.dm.cur == CODE_EXT) ? ext_q : 1'b0)))
      else $error("differential clock wrong for level-3 or external code");

   chk_e3_group: assert property (
      ($past(presetn) && s_r.e3m.mode == LCSD_FOLLOW)
      |-> e3_group_clk == (s_r.e3m.cur[0] ? ext_q : $past(pll2_clk)))
      else $error("level-3 group clock wrong");

   chk_e1_high: assert property (
      (s_r.hm.mode == LCSD_FOLLOW)
      |-> e1_hi_group_clk == (s_r.hm.cur[0] ? ext_q : $past(ps_out[0])))
      else $error("high low-rate group clock wrong");

   chk_e1_low: assert property (
      ($past(presetn) && s_r.lm.mode == LCSD_FOLLOW)
      |-> e1_lo_group_clk == (s_r.lm.cur[0] ? ext_q : $past(pll3_clk)))
      else $error("low low-rate group clock wrong");

   chk_drv_upper: assert property (
      (wr_en && paddr == ADDR_DRV)
      |=> diff_drv_oe[7:4] == {{2{$past(pwdata[3])}}, {2{$past(pwdata[2])}}})
      else $error("upper driver pairs not set by write");

   chk_drv_lower: assert property (
      (wr_en && paddr == ADDR_DRV)
      |=> diff_drv_oe[3:0] == {{2{$past(pwdata[1])}}, {2{$past(pwdata[0])}}}
          ##1 $stable(diff_drv_oe) || $past(wr_en))
      else $error("lower driver pairs not set by write");

   chk_edge_write: assert property (
      (wr_en && paddr == ADDR_EDGE) |=> rx_rise_edge == $past(pwdata[7:0]))
      else $error("edge bits not set by write");

   chk_div_store: assert property (
      (wr_en && paddr == ADDR_DIV1) |=> s_r.div1 == $past(pwdata[15:0]))
      else $error("PLL 1 divider not stored");

   chk_park_low: assert property (
      (s_r.dm.mode == LCSD_PARK) |=> diff_out_clock_source_out == 8'h00)
      else $error("differential clock not parked low while switching");

   // Register path: stores, holds and read words
   chk_sel_store: assert property (
      (wr_en && paddr == ADDR_SEL) |=> s_r.sel == $past(pwdata[7:0]))
      else $error("select register not stored");

   chk_sel_hold: assert property (
      !wr_en |=> $stable(s_r.sel))
      else $error("select register moved without a write");

   chk_div0_store: assert property (
      (wr_en && paddr == ADDR_DIV0) |=> s_r.div0 == $past(pwdata[15:0]))
      else $error("PLL 0 divider not stored");

   chk_div_hold: assert property (
      !wr_en |=> $stable(s_r.div0) && $stable(s_r.div1))
      else $error("divider moved without a write");

   chk_drv_read: assert property (
      (psel && !penable && paddr == ADDR_DRV) |=> prdata[31:4] == 28'h0000000)
      else $error("unused driver enable bits read nonzero");

   chk_edge_read: assert property (
      (psel && !penable && paddr == ADDR_EDGE)
      |=> prdata == {24'h000000, $past(rx_rise_edge)})
      else $error("edge bits read back wrong");

   chk_div0_read: assert property (
      (psel && !penable && paddr == ADDR_DIV0)
      |=> prdata == {16'h0000, $past(s_r.div0)})
      else $error("PLL 0 divider read back wrong");

   chk_div1_read: assert property (
      (psel && !penable && paddr == ADDR_DIV1)
      |=> prdata == {16'h0000, $past(s_r.div1)})
      else $error("PLL 1 divider read back wrong");

   // Undefined codes and rejoining of the differential mux, parking of the group muxes
   chk_undef_code: assert property (
      (s_r.dm.mode == LCSD_FOLLOW && s_r.dm.cur > CODE_EXT) |-> diff_out_clock_source_out == 8'h00)
      else $error("undefined differential code not held low");

   chk_join_low: assert property (
      ($past(s_r.dm.mode) == LCSD_PARK && s_r.dm.mode == LCSD_FOLLOW)
      |-> diff_out_clock_source_out == 8'h00)
      else $error("differential clock high when joining new source");

   chk_e3_park: assert property (
      (s_r.e3m.mode == LCSD_PARK) |=> e3_group_clk == 1'b0)
      else $error("level-3 group clock not parked low while switching");

   chk_hi_park: assert property (
      (s_r.hm.mode == LCSD_PARK) |=> e1_hi_group_clk == 1'b0)
      else $error("high low-rate group clock not parked low while switching");

   chk_lo_park: assert property (
      (s_r.lm.mode == LCSD_PARK) |=> e1_lo_group_clk == 1'b0)
      else $error("low low-rate group clock not parked low while switching");

   // Main scenarios
   cov_switch: cover property (
      s_r.dm.mode == LCSD_PARK ##1 s_r.dm.mode == LCSD_FOLLOW);
   cov_ext: cover property (
      s_r.dm.mode == LCSD_FOLLOW && s_r.dm.cur == CODE_EXT);
   cov_div_write: cover property (wr_en && paddr == ADDR_DIV0);
   cov_bad_addr: cover property (pslverr);
   cov_group_ext: cover property (
      s_r.e3m.mode == LCSD_FOLLOW && s_r.e3m.cur[0]);

endmodule

`default_nettype wire

//--- core/lcsd_pkg.sv
// Behaviour
// - Select bits 7-3 pick one source for all eight differential outputs; zero means PLL 1.
// - Differential codes 1 to 16 pick receive clocks 0 to 15 of the low-rate lines.
// - Codes 17 to 20 pick level-3 receive clocks 0 to 3; 21 is external.
// - Select bit 2 picks the level-3 group clock; zero means PLL-derived clock.
// - Select bit 1 picks clock for low-rate lines 8 to 15; zero means PLL-derived.
// - Select bit 0 picks clock for low-rate lines 0 to 7; zero means PLL-derived.
// - Driver enable bit 3 drives channels 6 and 7, bit 2 channels 4 and 5.
// - Bit 1 drives channels 2 and 3, bit 0 channels 0 and 1; bits 7-4 unused.
// - Each edge bit set makes its channel receive on the rising clock edge.
// - A 16-bit post-scale value divides PLL 0 for high low-rate lines.
// - A second 16-bit post-scale value divides PLL 1 for the differential channels.
// - Each divided PLL clock is halved again for an even duty cycle.
package lcsd_pkg;

   // ****************************************
   // Register indices and byte addresses
   // ****************************************
   localparam logic [7:0] IDX_SEL = 8'h21;
   localparam logic [7:0] IDX_DRV = 8'h22;
   localparam logic [7:0] IDX_EDGE = 8'h23;
   localparam logic [7:0] IDX_DIV0 = 8'h24;
   localparam logic [7:0] IDX_DIV1 = 8'h26;
   localparam logic [7:0] ADDR_SEL = {IDX_SEL[5:0], 2'h0};
   localparam logic [7:0] ADDR_DRV = {IDX_DRV[5:0], 2'h0};
   localparam logic [7:0] ADDR_EDGE = {IDX_EDGE[5:0], 2'h0};
   localparam logic [7:0] ADDR_DIV0 = {IDX_DIV0[5:0], 2'h0};
   localparam logic [7:0] ADDR_DIV1 = {IDX_DIV1[5:0], 2'h0};

   // ****************************************
   // Field positions, codes and reset values
   // ****************************************
   localparam int SEL_DIFF_MSB = 7;
   localparam int SEL_DIFF_LSB = 3;
   localparam int SEL_E3_BIT = 2;
   localparam int SEL_E1HI_BIT = 1;
   localparam int SEL_E1LO_BIT = 0;
   localparam logic [4:0] CODE_PLL1 = 5'h00;
   localparam logic [4:0] CODE_E1_FIRST = 5'h01;
   localparam logic [4:0] CODE_E3_FIRST = 5'h11;
   localparam logic [4:0] CODE_EXT = 5'h15;
   localparam logic [7:0] RST_SEL = 8'h00;
   localparam logic [3:0] RST_DRV = 4'h0;
   localparam logic [7:0] RST_EDGE = 8'h00;
   localparam logic [15:0] RST_DIV = 16'h0000;
   localparam logic [15:0] DIV_UNITY = 16'h0001;

   // ****************************************
   // State types
   // ****************************************
   typedef enum logic {LCSD_FOLLOW, LCSD_PARK} lcsd_mux_e;

   typedef struct packed {
      lcsd_mux_e mode;
      logic [4:0] cur;
      logic out;
   } lcsd_mux_s;

   typedef struct packed {
      logic [7:0] sel;
      logic [3:0] drv;
      logic [7:0] edge_sel;
      logic [15:0] div0;
      logic [15:0] div1;
      logic [31:0] rdata;
      lcsd_mux_s dm;
      lcsd_mux_s e3m;
      lcsd_mux_s hm;
      lcsd_mux_s lm;
   } lcsd_state_s;

   typedef struct packed {
      logic prev;
      logic [15:0] cnt;
      logic out;
   } lcsd_ps_s;

endpackage

//--- core/lcsd_ps_if.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Post-scaler link: source level, divider value, divided clock
// ****************************************
interface lcsd_ps_if;
   logic src;
   logic [15:0] div;
   logic out;
   modport scaler (input src, input div, output out);
   modport owner (output src, output div, input out);
endinterface

`default_nettype wire

//--- core/lcsd_post_scaler.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Post-scale divider with final divide-by-two
// ****************************************
module lcsd_post_scaler
   import lcsd_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Source and divided clock
   lcsd_ps_if.scaler bus
);

   lcsd_ps_s s_r;
   lcsd_ps_s s_nxt;
   logic rise;
   logic [15:0] lim;
   logic wrap;

   // Divider value 0 or 1 means no division
   assign lim = (bus.div <= DIV_UNITY) ? DIV_UNITY : bus.div;
   assign rise = bus.src && !s_r.prev;
   assign wrap = ({1'b0, s_r.cnt} + 17'h00001) >= {1'b0, lim};

   // Count source rising edges, toggle the output every lim of them
   always_comb begin
      s_nxt = s_r;
      s_nxt.prev = bus.src;
      if (rise) begin
         if (wrap) begin
            s_nxt.cnt = 16'h0000;
            s_nxt.out = !s_r.out;
         end else begin
            s_nxt.cnt = 16'(s_r.cnt + 16'h0001);
         end
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.out = s_r.out;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_toggle_cause: assert property (
      $changed(bus.out) |-> $past(rise && wrap))
      else $error("divided clock changed without its counted edge");
   chk_unity_div: assert property (
      (rise && lim == DIV_UNITY) |=> $changed(bus.out))
      else $error("undivided clock did not follow source edge");
   chk_cnt_hold: assert property (
      (!rise && $stable(bus.div)) |=> $stable(s_r.cnt) && $stable(bus.out))
      else $error("divider moved without a source edge");

endmodule

`default_nettype wire

//--- sim/lcsd_line_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Far-side clock sources: PLLs, line receivers, external clock
// ****************************************
module lcsd_line_model (
   // Reference clock
   input wire logic pclk,
   // PLL clocks
   output logic pll0_clk,
   output logic pll1_clk,
   output logic pll2_clk,
   output logic pll3_clk,
   // Line receive and external clocks
   output logic [15:0] e1_rx_clk,
   output logic [3:0] e3_rx_clk,
   output logic ext_clk
);
   int cyc = 0;
   logic [24:0] src_r = 25'h0000000;

   // Source i toggles every i+2 cycles, right after the rising edge
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      for (int i = 0; i < 25; i++) begin
         src_r[i] <= ((cyc + 1) / (i + 2)) % 2 == 1;
      end
   end

   // Distinct rates let a wrong selection show as a mismatch
   assign {ext_clk, e3_rx_clk, e1_rx_clk, pll3_clk, pll2_clk, pll1_clk, pll0_clk} = src_r;
endmodule

`default_nettype wire

//--- sim/line_clock_select_divider_bench.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Register and clock routing bench
// ****************************************
module line_clock_select_divider_bench
   import lcsd_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pll0_clk, pll1_clk, pll2_clk, pll3_clk, ext_clk;
   logic [15:0] e1_rx_clk;
   logic [3:0] e3_rx_clk;
   logic [7:0] diff_out_clock_source_out, diff_drv_oe, rx_rise_edge;
   logic e3_group_clk, e1_hi_group_clk, e1_lo_group_clk;
   wire logic [25:0] src;
   int err_count = 0;
   int checks_done = 0;
   int run_hi = 0;
   logic [31:0] rd_q;
   logic rd_e;
   logic [7:0] addrs [5] = '{ADDR_SEL, ADDR_DRV, ADDR_EDGE, ADDR_DIV0, ADDR_DIV1};
   logic [31:0] masks [5] = '{32'hFF, 32'hF, 32'hFF, 32'hFFFF, 32'hFFFF};

   // Source index 25 is a constant low level, the parked state
   assign src = {1'b0, ext_clk, e3_rx_clk, e1_rx_clk, pll3_clk, pll2_clk, pll1_clk, pll0_clk};

   // Clock source
   initial begin
      forever #25 pclk = ~pclk;
   end

   lcsd_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .pll0_clk, .pll1_clk, .pll2_clk, .pll3_clk, .e1_rx_clk,
      .e3_rx_clk, .ext_clk, .diff_out_clock_source_out, .diff_drv_oe, .rx_rise_edge, .e3_group_clk,
      .e1_hi_group_clk, .e1_lo_group_clk);

   lcsd_line_model far_side (.pclk, .pll0_clk, .pll1_clk, .pll2_clk, .pll3_clk,
      .e1_rx_clk, .e3_rx_clk, .ext_clk);

   // ****************************************
   // Helpers
   // ****************************************
   task automatic results();
      if (err_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask

   task automatic hang(input string name);
      $display("BAD %s expected done seen timeout", name);
      err_count++;
      results();
   endtask

   // One APB transfer, entered just after a rising edge, with an idle edge after
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) hang("pready");
      rd_q = prdata;
      rd_e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
      apb(1'b0, a, 32'h0);
      chk($sformatf("read %h", a), exp, rd_q);
      chk($sformatf("error %h", a), {31'h0, err}, {31'h0, rd_e});
   endtask

   task automatic step();
      @(posedge pclk);
      #1;
   endtask

   function automatic logic outv(input int o);
      case (o)
         0: return diff_out_clock_source_out[0];
         1: return e3_group_clk;
         2: return e1_hi_group_clk;
         default: return e1_lo_group_clk;
      endcase
   endfunction

   // After settling, output o must show source s one cycle later
   task automatic follow(input int o, input int s);
      logic v;
      repeat (60) @(posedge pclk);
      #1;
      for (int k = 0; k < 40; k++) begin
         v = src[s];
         step();
         chk($sformatf("out %0d src %0d", o, s), {31'h0, v}, {31'h0, outv(o)});
         chk("pair copies", {24'h0, {8{diff_out_clock_source_out[0]}}}, {24'h0, diff_out_clock_source_out});
      end
      @(posedge pclk);
   endtask

   // Measures one full high and low run of output o
   task automatic meas(input int o, input int hi);
      int n;
      int h;
      int l;
      n = 0;
      h = 0;
      l = 0;
      repeat (100) @(posedge pclk);
      step();
      while (outv(o) !== 1'b0 && n < 3000) begin
         step();
         n++;
      end
      while (outv(o) !== 1'b1 && n < 3000) begin
         step();
         n++;
      end
      while (outv(o) === 1'b1 && n < 3000) begin
         step();
         n++;
         h++;
      end
      while (outv(o) === 1'b0 && n < 3000) begin
         step();
         n++;
         l++;
      end
      if (n >= 3000) hang("divided clock");
      chk($sformatf("high run %0d", o), 32'(hi), 32'(h));
      chk($sformatf("low run %0d", o), 32'(hi), 32'(l));
      @(posedge pclk);
   endtask

   // A single-cycle high pulse on the shared clock is a switching glitch
   always @(negedge pclk) begin
      if (diff_out_clock_source_out[0] === 1'b1) begin
         run_hi++;
      end else begin
         if (run_hi == 1) chk("pulse width", 32'h2, 32'h1);
         run_hi = 0;
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      int mx;
      int nv [3];
      nv = '{0, 1, 3};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values, then widths of each register
      for (int i = 0; i < 5; i++) rd(addrs[i], 32'h0, 1'b0);
      chk("driver enables", 32'h0, {24'h0, diff_drv_oe});
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, addrs[i], 32'hFFFF_FFFF);
         rd(addrs[i], masks[i], 1'b0);
      end
      rd(8'h94, 32'h0, 1'b1);
      // Pair driver enables, one bit at a time
      for (int p = 0; p < 4; p++) begin
         apb(1'b1, ADDR_DRV, 32'h1 << p);
         chk("driver enables", 32'h3 << (2 * p), {24'h0, diff_drv_oe});
      end
      // Receive edge bits
      apb(1'b1, ADDR_EDGE, 32'h0000_A5C3);
      rd(ADDR_EDGE, 32'hC3, 1'b0);
      chk("receive edges", 32'hC3, {24'h0, rx_rise_edge});
      // Shared transmit clock codes, the last one undefined
      for (int c = 1; c < 23; c++) begin
         apb(1'b1, ADDR_SEL, {24'h0, c[4:0], 3'h0});
         follow(0, (c < 22) ? c + 3 : 25);
      end
      // Group clock selection, one bit at a time
      for (int b = 0; b < 3; b++) begin
         apb(1'b1, ADDR_SEL, 32'h1 << b);
         follow(1, (b == 2) ? 24 : 2);
         follow(3, (b == 0) ? 24 : 3);
         if (b == 1) follow(2, 24);
      end
      // Post-scale dividers and the final halving
      apb(1'b1, ADDR_SEL, 32'h0);
      for (int i = 0; i < 3; i++) begin
         mx = (nv[i] > 1) ? nv[i] : 1;
         apb(1'b1, ADDR_DIV0, 32'(nv[i]));
         apb(1'b1, ADDR_DIV1, 32'(nv[i]));
         meas(2, 4 * mx);
         meas(0, 6 * mx);
      end
      results();
   end
endmodule

`default_nettype wire
